// >>> wdsrk_regs.vh
// register map, field layout, key codes and timing constants of the watchdog
`ifndef WDSRK_REGS_VH
`define WDSRK_REGS_VH
// register indexes; byte address is four times the index
`define WDSRK_IDX_KEY 8'ha6
`define WDSRK_IDX_CTL 8'ha7
// control/status field positions
`define WDSRK_PS_MSB 7
`define WDSRK_PS_LSB 5
`define WDSRK_IDLE_BIT 4
`define WDSRK_SOFT_RESET_FLAG_BIT 2
`define WDSRK_OVF_BIT 1
`define WDSRK_EN_BIT 0
// reset values
`define WDSRK_PS_RST 3'h0
`define WDSRK_CTL_RST 8'h00
// key bytes
`define WDSRK_KEY_FEED1 8'h1e
`define WDSRK_KEY_FEED2 8'he1
`define WDSRK_KEY_RST1 8'h5a
`define WDSRK_KEY_RST2 8'ha5
// timing
`define WDSRK_BASE_EXP 14
`define WDSRK_CNT_W 21
`define WDSRK_RST_PULSE 3'h4
`endif

// >>> wdsrk_key_seq.v
// two-byte key sequence checker for the watchdog key port
`timescale 1ns/10ps
`include "wdsrk_regs.vh"
module wdsrk_key_seq (
  input wire clk_i,
  input wire arst_n_i,
  input wire clr_i,
  input wire wr_i,
  input wire [7:0] data_i,
  output wire feed_o,
  output wire soft_reset_flag_o,
  output wire bad_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_FEED = 2'h1;
  localparam ST_RST = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg feed;
  reg soft_reset_flag;
  reg bad;

  always @* begin
    state_nxt = state_r;
    feed = 1'b0;
    soft_reset_flag = 1'b0;
    bad = 1'b0;
    if (wr_i) begin
      case (state_r)
        ST_IDLE: begin
          if (data_i == `WDSRK_KEY_FEED1) begin
            state_nxt = ST_FEED;
          end else if (data_i == `WDSRK_KEY_RST1) begin
            state_nxt = ST_RST;
          end else begin
            bad = 1'b1;
          end
        end
        ST_FEED: begin
          state_nxt = ST_IDLE;
          feed = (data_i == `WDSRK_KEY_FEED2);
          bad = (data_i != `WDSRK_KEY_FEED2);
        end
        ST_RST: begin
          state_nxt = ST_IDLE;
          soft_reset_flag = (data_i == `WDSRK_KEY_RST2);
          bad = (data_i != `WDSRK_KEY_RST2);
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    if (clr_i) begin
      state_nxt = ST_IDLE;
      feed = 1'b0;
      soft_reset_flag = 1'b0;
      bad = 1'b0;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign feed_o = feed;
  assign soft_reset_flag_o = soft_reset_flag;
  assign bad_o = bad;
endmodule // wdsrk_key_seq

// >>> wdsrk_top.v
// watchdog with software reset keys behind an Avalon-MM slave
`timescale 1ns/10ps
`include "wdsrk_regs.vh"
module wdsrk_top #(
  parameter BASE_EXP = `WDSRK_BASE_EXP
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire [9:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire idle_i,
  input wire powerdown_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  output wire sys_rst_o
);
  reg waitreq_r;
  reg [31:0] rdata_r;
  reg [2:0] period_sel_r;
  reg idle_freeze_r;
  reg soft_reset_flag_r;
  reg overflow_cause_flag_r;
  reg counter_enabled_r;
  reg [`WDSRK_CNT_W-1:0] watchdog_counter_r;
  reg [2:0] rst_cnt_r;
  reg sys_rst_r;

  reg soft_reset_flag_nxt;
  reg overflow_cause_flag_nxt;
  reg [`WDSRK_CNT_W-1:0] watchdog_counter_nxt;

  wire key_feed;
  wire key_soft_reset_flag;
  wire key_bad;

  // last count value of the selected period
  function [`WDSRK_CNT_W-1:0] period_last;
    input [2:0] sel;
    reg [`WDSRK_CNT_W:0] span;
    begin
      span = {{`WDSRK_CNT_W{1'b0}}, 1'b1} << (sel + BASE_EXP);
      period_last = span[`WDSRK_CNT_W-1:0] - {{(`WDSRK_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  function hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // access commits at the edge where waitrequest is seen low
  wire commit = (avs_read_i | avs_write_i) & ~waitreq_r;
  wire wr_low = avs_write_i & ~waitreq_r & avs_byteenable_i[0];
  wire key_wr = wr_low & hit(avs_address_i, `WDSRK_IDX_KEY);
  wire ctl_wr = wr_low & hit(avs_address_i, `WDSRK_IDX_CTL);

  wire [7:0] ctl_view = {period_sel_r, idle_freeze_r, 1'b0, soft_reset_flag_r,
                         overflow_cause_flag_r, counter_enabled_r};

  wire frozen = powerdown_i | (idle_i & idle_freeze_r);
  wire timeout = counter_enabled_r & ~frozen & ~sys_rst_r &
                 (watchdog_counter_r == period_last(period_sel_r));
  wire fire = key_soft_reset_flag | key_bad | timeout;

  wdsrk_key_seq u_key (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(sys_rst_r),
    .wr_i(key_wr),
    .data_i(avs_writedata_i[7:0]),
    .feed_o(key_feed),
    .soft_reset_flag_o(key_soft_reset_flag),
    .bad_o(key_bad)
  );

  // bus slave: one wait cycle, then one ready cycle
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      waitreq_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      if (commit) begin
        waitreq_r <= 1'b1;
      end else if (avs_read_i | avs_write_i) begin
        waitreq_r <= 1'b0;
        if (avs_read_i && hit(avs_address_i, `WDSRK_IDX_CTL)) begin
          rdata_r <= {24'h0, ctl_view};
        end else begin
          rdata_r <= 32'h0;
        end
      end
    end
  end

  // flags: hardware set wins over software write
  always @* begin
    soft_reset_flag_nxt = soft_reset_flag_r;
    overflow_cause_flag_nxt = overflow_cause_flag_r;
    if (ctl_wr) begin
      soft_reset_flag_nxt = avs_writedata_i[`WDSRK_SOFT_RESET_FLAG_BIT];
      overflow_cause_flag_nxt = avs_writedata_i[`WDSRK_OVF_BIT];
    end
    if (key_soft_reset_flag) begin
      soft_reset_flag_nxt = 1'b1;
    end
    if (key_bad) begin
      soft_reset_flag_nxt = 1'b1;
      overflow_cause_flag_nxt = 1'b1;
    end
    if (timeout) begin
      overflow_cause_flag_nxt = 1'b1;
    end
  end

  always @* begin
    watchdog_counter_nxt = watchdog_counter_r;
    if (sys_rst_r || key_feed || !counter_enabled_r) begin
      watchdog_counter_nxt = {`WDSRK_CNT_W{1'b0}};
    end else if (timeout) begin
      watchdog_counter_nxt = {`WDSRK_CNT_W{1'b0}};
    end else if (!frozen) begin
      watchdog_counter_nxt = watchdog_counter_r + {{(`WDSRK_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      period_sel_r <= `WDSRK_PS_RST;
      idle_freeze_r <= 1'b0;
      soft_reset_flag_r <= 1'b0;
      overflow_cause_flag_r <= 1'b0;
      counter_enabled_r <= 1'b0;
      watchdog_counter_r <= {`WDSRK_CNT_W{1'b0}};
      rst_cnt_r <= 3'h0;
      sys_rst_r <= 1'b0;
    end else begin
      if (ctl_wr) begin
        period_sel_r <= avs_writedata_i[`WDSRK_PS_MSB:`WDSRK_PS_LSB];
        idle_freeze_r <= avs_writedata_i[`WDSRK_IDLE_BIT];
      end
      soft_reset_flag_r <= soft_reset_flag_nxt;
      overflow_cause_flag_r <= overflow_cause_flag_nxt;
      watchdog_counter_r <= watchdog_counter_nxt;
      if (sys_rst_r || fire) begin
        counter_enabled_r <= 1'b0;
      end else if (key_feed) begin
        counter_enabled_r <= 1'b1;
      end
      // reset pulse on soft-reset or bad key regardless of enable state; timeout pulses only while enabled
      if (fire && !sys_rst_r) begin
        sys_rst_r <= 1'b1;
        rst_cnt_r <= `WDSRK_RST_PULSE - 3'h1;
      end else if (sys_rst_r) begin
        if (rst_cnt_r == 3'h0) begin
          sys_rst_r <= 1'b0;
        end else begin
          rst_cnt_r <= rst_cnt_r - 3'h1;
        end
      end
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = waitreq_r;
  assign sys_rst_o = sys_rst_r;
endmodule // wdsrk_top

// >>> wdsrk_checker.sv
// port assertions for the watchdog key unit
`timescale 1ns/10ps
module wdsrk_checker (
  input wire clk_i,
  input wire arst_n_i,
  input wire [9:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire sys_rst_o
);
  // key writes during a reset pulse are dropped by the design
  wire kc = avs_write_i && avs_byteenable_i[0] && !avs_waitrequest_o && !sys_rst_o &&
            avs_address_i == 10'h298;
  wire [7:0] d = avs_writedata_i[7:0];
  reg pend_r;
  reg [7:0] last_r;
  wire good = pend_r && (last_r == 8'h1e && d == 8'he1 || last_r == 8'h5a && d == 8'ha5);
  wire first = !pend_r && (d == 8'h1e || d == 8'h5a);
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) pend_r <= 1'b0;
    else if (kc || sys_rst_o) pend_r <= kc && first;
  always @(posedge clk_i) if (kc) last_r <= d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_ACK: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("no ack");
  AST_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("ack held");
  AST_LEN: assert property ($rose(sys_rst_o) |=> sys_rst_o [*3] ##1 !sys_rst_o)
    else $error("pulse length");
  AST_SOFT: assert property (kc && good && last_r == 8'h5a |=> $rose(sys_rst_o))
    else $error("no soft reset");
  AST_FEED: assert property (kc && good && last_r == 8'h1e |=> !sys_rst_o)
    else $error("feed reset");
  AST_BAD: assert property (kc && !good && !first |=> $rose(sys_rst_o))
    else $error("no error reset");
  AST_FIRST: assert property (kc && first |=> !sys_rst_o)
    else $error("first key reset");
  AST_HI: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits");
  cover property (kc && good);
  cover property (kc && !good && !first);
  cover property ($rose(sys_rst_o));
endmodule // wdsrk_checker
bind wdsrk_top wdsrk_checker wdsrk_checker_i (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .sys_rst_o);

// >>> wdsrk_top_test.sv
// self-checking bench for the watchdog key unit
`timescale 1ns/10ps
module wdsrk_top_test;
  localparam KEY = 10'h298;
  localparam CTL = 10'h29c;
  reg clk_i = 1'b0, arst_n_i = 1'b0, rq = 1'b0, wq = 1'b0, idl = 1'b0, pd = 1'b0;
  reg [9:0] a = 10'h000;
  reg [31:0] wd = 32'h0, rv;
  wire [31:0] rd;
  wire wt, sr;
  integer miscompares = 0, checked = 0, pulses = 0, cyc = 0, dp = 0, t0, p, i;
  wdsrk_top #(.BASE_EXP(3)) wdsrk_top_i (.clk_i, .arst_n_i, .avs_address_i(a), .avs_read_i(rq),
    .avs_write_i(wq), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .idle_i(idl),
    .powerdown_i(pd), .avs_readdata_o(rd), .avs_waitrequest_o(wt), .sys_rst_o(sr));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge sr) pulses = pulses + 1;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checked = checked + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input w, input [9:0] ad, input [7:0] dt);
    a <= ad;
    wd <= {24'h0, dt};
    rq <= !w;
    wq <= w;
    @(posedge clk_i);
    while (wt !== 1'b0) @(posedge clk_i);
    rv = rd;
    rq <= 1'b0;
    wq <= 1'b0;
    @(posedge clk_i);
  endtask
  task waitp;
    while (pulses == p) @(posedge clk_i);
    chk(pulses - p, 1);
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    acc(0, CTL, 8'h00);
    chk(rv, 32'h0);
    p = pulses;
    acc(1, KEY, 8'h5a);
    acc(1, KEY, 8'ha5);
    waitp;
    acc(0, CTL, 8'h00);
    chk(rv, 32'h04);
    $display("soft reset test done");
    for (i = 0; i < 2; i = i + 1) begin
      acc(1, CTL, 8'h00);
      p = pulses;
      acc(1, KEY, i ? 8'h1e : 8'h33);
      if (i) acc(1, KEY, 8'h5a);
      waitp;
      acc(0, CTL, 8'h00);
      chk(rv, 32'h06);
    end
    $display("bad key test done");
    for (i = 0; i < 2; i = i + 1) begin
      acc(1, CTL, {i[2:0], 5'h00});
      p = pulses;
      acc(1, KEY, 8'h1e);
      acc(1, KEY, 8'he1);
      t0 = cyc;
      acc(0, CTL, 8'h00);
      chk(rv, {i[2:0], 5'h01});
      waitp;
      dp = cyc - t0 - dp;
      acc(0, CTL, 8'h00);
      chk(rv, {i[2:0], 5'h02});
    end
    chk(dp, 8);
    $display("timeout test done");
    // refeeding inside the period keeps the pulse away
    acc(1, CTL, 8'h20);
    p = pulses;
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, KEY, 8'h1e);
      acc(1, KEY, 8'he1);
    end
    chk(pulses - p, 0);
    waitp;
    $display("feed test done");
    // power-down, then idle with freeze set, hold the count
    acc(1, CTL, 8'h10);
    p = pulses;
    acc(1, KEY, 8'h1e);
    acc(1, KEY, 8'he1);
    pd <= 1'b1;
    repeat (12) @(posedge clk_i);
    pd <= 1'b0;
    idl <= 1'b1;
    acc(0, CTL, 8'h00);
    chk(rv, 32'h11);
    repeat (12) @(posedge clk_i);
    chk(pulses - p, 0);
    idl <= 1'b0;
    waitp;
    $display("freeze test done");
    // full field write, then a reset in mid-run clears everything
    acc(1, CTL, 8'hf7);
    acc(0, CTL, 8'h00);
    chk(rv, 32'hf6);
    acc(1, KEY, 8'h1e);
    acc(1, KEY, 8'he1);
    acc(0, CTL, 8'h00);
    chk(rv, 32'hf7);
    p = pulses;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    acc(0, CTL, 8'h00);
    chk(rv, 32'h00);
    chk(pulses - p, 0);
    $display("reset test done");
    report_and_stop;
  end
endmodule // wdsrk_top_test
